/* logic/aofc_frame_ctrl.sv */
// Output frame control: registers, frame assembly and frame FIFO
// Function
// - Reserved bits of output frame control read zero, upper half too.
// - Address-include bit appends the 4-bit device address to frames.
// - Supply alarm select adds high, low, both or no supply flags.
// - Input alarm select adds high, low, both or no input flags.
// - Range-include bit appends the 4-bit range code to frames.
// - Parity enable appends result parity and frame parity at the end.
// - Result parity is even parity over conversion bits only.
// - Frame parity is even over whole frame, excluding result parity.
// - Parity makes each frame two bits longer; host reads more bits.
// - Pattern codes 0xx real data, 100 all zeros, 101 all ones.
// - Code 110 alternates single bits, 111 alternates bit pairs.
// - Output control register is four bytes at 10h to 13h.
// - Register at 14h holds reference disable and range code.
// - Power-on-only fields and the 18h frame count ignore application reset; others clear on both.
// - Reference disable bit clear keeps reference on, set turns it off.
// - Range code top bit clear is bipolar, set is unipolar.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module aofc_frame_ctrl #(
   parameter int CONV_BITS  = aofc_pkg::CONV_BITS,
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                 clk_i,
   input  wire logic                 srst_i,
   input  wire logic                 app_rst_i,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic                      pready,
   output logic      [31:0]          prdata,
   output logic                      pslverr,
   input  wire logic [3:0]           device_addr_i,
   input  wire logic                 supply_alarm_high_i,
   input  wire logic                 supply_alarm_low_i,
   input  wire logic                 input_alarm_high_i,
   input  wire logic                 input_alarm_low_i,
   input  wire logic [CONV_BITS-1:0] conv_data_i,
   input  wire logic                 conv_valid_i,
   output logic                      conv_ready_o,
   output logic      [31:0]          frame_data_o,
   output logic      [5:0]           frame_len_o,
   output logic                      frame_valid_o,
   input  wire logic                 frame_ready_i,
   output logic                      internal_reference_off_o,
   output logic      [3:0]           range_code_o,
   output logic                      range_unipolar_o
);
   // ------------------------------------------------------------
   // Input synchronisers for alarm pins
   // ------------------------------------------------------------
   logic [3:0] alarm_meta_reg;
   logic [3:0] alarm_sync_reg;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         alarm_meta_reg <= 4'h0;
         alarm_sync_reg <= 4'h0;
      end else begin
         alarm_meta_reg <= {supply_alarm_low_i, supply_alarm_high_i,
                            input_alarm_low_i, input_alarm_high_i};
         alarm_sync_reg <= alarm_meta_reg;
      end
   end
   wire sup_low  = alarm_sync_reg[3];
   wire sup_high = alarm_sync_reg[2];
   wire in_low   = alarm_sync_reg[1];
   wire in_high  = alarm_sync_reg[0];

   // ------------------------------------------------------------
   // APB register file
   // ------------------------------------------------------------
   logic [31:0] frame_ctl_reg;
   logic [31:0] range_ref_reg;
   logic [31:0] frame_cnt_reg;
   wire         wr_en      = psel && penable && pwrite;
   wire         hit_ctl    = (paddr == aofc_pkg::OFS_FRAME_CTL);
   wire         hit_range  = (paddr == aofc_pkg::OFS_RANGE_REF);
   wire         hit_status = (paddr == aofc_pkg::OFS_FRAME_STATUS);
   wire         hit_any    = hit_ctl || hit_range || hit_status;
   wire [31:0]  byte_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}},
                              {8{pstrb[1]}}, {8{pstrb[0]}}};

   function automatic logic [31:0] merge_write(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [31:0] lanes,
      input logic [31:0] field_mask
   );
      logic [31:0] sel;
      sel = lanes & field_mask;
      merge_write = (old_val & ~sel) | (new_val & sel);
   endfunction : merge_write

   // Application reset clears only the fields without power-on marking
   function automatic logic [31:0] app_clear(
      input logic [31:0] old_val,
      input logic [31:0] por_mask,
      input logic [31:0] rst_val
   );
      app_clear = (old_val & por_mask) | (rst_val & ~por_mask);
   endfunction : app_clear

   wire [31:0] ctl_next_w = merge_write(frame_ctl_reg, pwdata, byte_mask,
                                        aofc_pkg::MASK_FRAME_CTL);
   wire [31:0] rng_next_w = merge_write(range_ref_reg, pwdata, byte_mask,
                                        aofc_pkg::MASK_RANGE_REF);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         frame_ctl_reg <= aofc_pkg::RST_FRAME_CTL;
         range_ref_reg <= aofc_pkg::RST_RANGE_REF;
      end else if (app_rst_i) begin
         frame_ctl_reg <= app_clear(frame_ctl_reg, aofc_pkg::MASK_POR_CTL,
                                    aofc_pkg::RST_FRAME_CTL);
         range_ref_reg <= app_clear(range_ref_reg, aofc_pkg::MASK_POR_RANGE,
                                    aofc_pkg::RST_RANGE_REF);
      end else if (wr_en) begin
         if (hit_ctl) begin
            frame_ctl_reg <= ctl_next_w;
         end
         if (hit_range) begin
            range_ref_reg <= rng_next_w;
         end
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit_any;
   always_comb begin
      prdata = 32'h0000_0000;
      if (hit_ctl) begin
         prdata = frame_ctl_reg & aofc_pkg::MASK_FRAME_CTL;
      end else if (hit_range) begin
         prdata = range_ref_reg & aofc_pkg::MASK_RANGE_REF;
      end else if (hit_status) begin
         prdata = frame_cnt_reg;
      end
   end

   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   wire       addr_en   = frame_ctl_reg[aofc_pkg::POS_ADDR_EN];
   wire [1:0] sup_sel   = frame_ctl_reg[aofc_pkg::POS_SUP_SEL +: 2];
   wire [1:0] in_sel    = frame_ctl_reg[aofc_pkg::POS_IN_SEL +: 2];
   wire       range_en  = frame_ctl_reg[aofc_pkg::POS_RANGE_EN];
   wire       parity_append_enable    = frame_ctl_reg[aofc_pkg::POS_PARITY_APPEND_ENABLE];
   wire [2:0] pat_sel   = frame_ctl_reg[aofc_pkg::POS_PATTERN +: 3];
   wire [3:0] range_cd  = range_ref_reg[aofc_pkg::POS_RANGE_CODE +: 4];

   assign internal_reference_off_o = range_ref_reg[aofc_pkg::POS_REF_OFF];
   assign range_code_o             = range_cd;
   assign range_unipolar_o         = range_cd[3];

   // ------------------------------------------------------------
   // Frame assembly
   // ------------------------------------------------------------
   function automatic logic [CONV_BITS-1:0] pattern_word(
      input logic [2:0]           sel,
      input logic [CONV_BITS-1:0] conv
   );
      logic [CONV_BITS-1:0] w;
      w = conv;
      for (int i = 0; i < CONV_BITS; i++) begin
         case (sel)
            aofc_pkg::PAT_ZEROS: w[i] = 1'b0;
            aofc_pkg::PAT_ONES:  w[i] = 1'b1;
            aofc_pkg::PAT_ALT1:  w[i] = i[0];
            aofc_pkg::PAT_ALT2:  w[i] = i[1];
            default:             w[i] = conv[i];
         endcase
      end
      pattern_word = w;
   endfunction : pattern_word

   // Append bits at the low end; result stays right-aligned until frame_msb shifts it to the top
   function automatic logic [31:0] append_bits(
      input logic [31:0] acc,
      input logic [3:0]  bits,
      input int          n
   );
      logic [31:0] r;
      r = acc;
      for (int i = 0; i < 4; i++) begin
         if (i < n) begin
            r = {r[30:0], bits[n-1-i]};
         end
      end
      append_bits = r;
   endfunction : append_bits

   logic [31:0] body;
   logic [5:0]  body_len;
   logic [3:0]  sup_bits;
   logic [3:0]  in_bits;
   int          sup_n;
   int          in_n;
   wire  [CONV_BITS-1:0] conv_word = pattern_word(pat_sel, conv_data_i);
   wire  res_par = ^conv_word;

   always_comb begin
      sup_bits = 4'h0;
      in_bits  = 4'h0;
      sup_n    = 0;
      in_n     = 0;
      case (sup_sel)
         2'h1: begin sup_bits = {3'h0, sup_high}; sup_n = 1; end
         2'h2: begin sup_bits = {3'h0, sup_low};  sup_n = 1; end
         2'h3: begin sup_bits = {2'h0, sup_high, sup_low}; sup_n = 2; end
         default: sup_n = 0;
      endcase
      case (in_sel)
         2'h1: begin in_bits = {3'h0, in_high}; in_n = 1; end
         2'h2: begin in_bits = {3'h0, in_low};  in_n = 1; end
         2'h3: begin in_bits = {2'h0, in_high, in_low}; in_n = 2; end
         default: in_n = 0;
      endcase
      body     = 32'(conv_word);
      body_len = 6'(CONV_BITS);
      if (addr_en) begin
         body     = append_bits(body, device_addr_i, 4);
         body_len = body_len + 6'h04;
      end
      body     = append_bits(body, sup_bits, sup_n);
      body_len = body_len + 6'(sup_n);
      body     = append_bits(body, in_bits, in_n);
      body_len = body_len + 6'(in_n);
      if (range_en) begin
         body     = append_bits(body, range_cd, 4);
         body_len = body_len + 6'h04;
      end
   end

   wire        frm_par   = ^body;
   wire [31:0] with_par  = append_bits(body, {2'h0, res_par, frm_par}, 2);
   wire [31:0] frame_raw = parity_append_enable ? with_par : body;
   wire [5:0]  frame_n   = parity_append_enable ? body_len + 6'h02 : body_len;
   wire [31:0] frame_msb = frame_raw << (6'(aofc_pkg::FRAME_MAX) - frame_n);

   // ------------------------------------------------------------
   // Frame FIFO: frames wait here for the serial shifter
   // ------------------------------------------------------------
   logic [37:0] fifo_out;
   aofc_frame_fifo #(
      .WIDTH (38),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_data_i   ({frame_n, frame_msb}),
      .in_valid_i  (conv_valid_i),
      .in_ready_o  (conv_ready_o),
      .out_data_o  (fifo_out),
      .out_valid_o (frame_valid_o),
      .out_ready_i (frame_ready_i)
   );
   assign frame_data_o = fifo_out[31:0];
   assign frame_len_o  = fifo_out[37:32];

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         frame_cnt_reg <= 32'h0000_0000;
      end else if (conv_valid_i && conv_ready_o) begin
         frame_cnt_reg <= frame_cnt_reg + 32'h0000_0001;
      end
   end
endmodule : aofc_frame_ctrl

/* logic/aofc_pkg.sv */
// Package: register map, field layout, reset values and pattern codes
package aofc_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_FRAME_CTL     = 8'h10;
   localparam logic [7:0] OFS_RANGE_REF     = 8'h14;
   localparam logic [7:0] OFS_FRAME_STATUS  = 8'h18;
   // ------------------------------------------------------------
   // Output frame control fields
   // ------------------------------------------------------------
   localparam int         POS_ADDR_EN       = 14;
   localparam int         POS_SUP_SEL       = 12;
   localparam int         POS_IN_SEL        = 10;
   localparam int         POS_RANGE_EN      = 8;
   localparam int         POS_PARITY_APPEND_ENABLE        = 3;
   localparam int         POS_PATTERN       = 0;
   localparam logic [31:0] MASK_FRAME_CTL   = 32'h0000_7D0F;
   localparam logic [31:0] MASK_POR_CTL     = 32'h0000_0008;
   localparam logic [31:0] RST_FRAME_CTL    = 32'h0000_0000;
   // ------------------------------------------------------------
   // Range and reference fields
   // ------------------------------------------------------------
   localparam int         POS_REF_OFF       = 6;
   localparam int         POS_RANGE_CODE    = 0;
   localparam logic [31:0] MASK_RANGE_REF   = 32'h0000_004F;
   localparam logic [31:0] MASK_POR_RANGE   = 32'h0000_000F;
   localparam logic [31:0] RST_RANGE_REF    = 32'h0000_0000;
   // ------------------------------------------------------------
   // Pattern select codes
   // ------------------------------------------------------------
   localparam logic [2:0] PAT_ZEROS         = 3'h4;
   localparam logic [2:0] PAT_ONES          = 3'h5;
   localparam logic [2:0] PAT_ALT1          = 3'h6;
   localparam logic [2:0] PAT_ALT2          = 3'h7;
   // ------------------------------------------------------------
   // Frame sizes
   // ------------------------------------------------------------
   localparam int         CONV_BITS         = 18;
   localparam int         FRAME_MAX         = 32;
   localparam int         FRAME_LEN_W       = 6;
endpackage : aofc_pkg

/* logic/aofc_frame_fifo.sv */
// Frame FIFO with valid/ready on both sides
`timescale 1ns/10ps
module aofc_frame_fifo #(
   parameter int WIDTH = 38,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              push = in_valid_i && in_ready_o;
   wire              pop  = out_valid_o && out_ready_i;

   assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign out_data_o  = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : aofc_frame_fifo

/* verif/aofc_frame_ctrl_chk.sv */
// Port-level assertions for the output frame control block
`timescale 1ns/10ps
module aofc_frame_ctrl_chk (
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic        app_rst_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        conv_valid_i,
   input wire logic        conv_ready_o,
   input wire logic [31:0] frame_data_o,
   input wire logic [5:0]  frame_len_o,
   input wire logic        frame_valid_o,
   input wire logic        frame_ready_i,
   input wire logic        internal_reference_off_o,
   input wire logic [3:0]  range_code_o,
   input wire logic        range_unipolar_o
);
   wire logic acc_w = psel && penable;
   wire logic rd_w  = acc_w && !pwrite;
   wire logic map_w = paddr inside {8'h10, 8'h14, 8'h18};
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   a_zero_wait: assert property (acc_w |-> pready)
      else $error("access without ready");
   a_unmapped_err: assert property (acc_w && !map_w |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_ctl_reserved: assert property (rd_w && paddr == 8'h10 |-> (prdata & 32'hFFFF_82F0) == 32'h0)
      else $error("reserved control bits not zero");
   a_range_view: assert property (rd_w && paddr == 8'h14 |-> prdata == {25'h0, internal_reference_off_o, 2'h0, range_code_o})
      else $error("range register read mismatch");
   a_unipolar_bit: assert property (range_unipolar_o == range_code_o[3])
      else $error("unipolar flag wrong");
   a_app_clear: assert property (app_rst_i && !(acc_w && pwrite) |=> !internal_reference_off_o && $stable(range_code_o))
      else $error("application reset effect wrong");
   a_frame_next: assert property (conv_valid_i && conv_ready_o && !frame_valid_o |=> frame_valid_o)
      else $error("accepted word gave no frame");
   a_head_hold: assert property (frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_data_o) && $stable(frame_len_o))
      else $error("stalled frame changed");
   a_len_range: assert property (frame_valid_o |-> frame_len_o >= 6'h12 && frame_len_o <= 6'h20)
      else $error("frame length out of range");
endmodule : aofc_frame_ctrl_chk
bind aofc_frame_ctrl aofc_frame_ctrl_chk u_chk (.clk_i, .srst_i, .app_rst_i,
   .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
   .conv_valid_i, .conv_ready_o, .frame_data_o, .frame_len_o,
   .frame_valid_o, .frame_ready_i, .internal_reference_off_o,
   .range_code_o, .range_unipolar_o);

/* verif/aofc_host_model.sv */
// Host that pops frames and counts the bits it clocks out
`timescale 1ns/10ps
module aofc_host_model (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       stall_i,
   input  wire logic       frame_valid_i,
   input  wire logic [5:0] frame_len_i,
   output logic            frame_ready_o,
   output logic     [15:0] bits_o
);
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         frame_ready_o <= 1'h0;
         bits_o        <= 16'h0;
      end else begin
         frame_ready_o <= !stall_i;
         if (frame_valid_i && frame_ready_o)
            bits_o <= bits_o + 16'(frame_len_i);
      end
   end
endmodule : aofc_host_model

/* verif/aofc_frame_ctrl_tb.sv */
// Testbench for the output frame control block
`timescale 1ns/10ps
module aofc_frame_ctrl_tb;
   logic        clk_i = 1'h0, srst_i = 1'h1, app_rst_i = 1'h0, stall = 1'h1;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0]  paddr = 8'h0;
   logic [3:0]  pstrb = 4'h0, dev = 4'hA, range_code_o;
   logic [31:0] pwdata = 32'h0, prdata, rd_d, cur_ctl, frame_data_o;
   logic        pready, pslverr, rd_e, sh = 1'h0, sl = 1'h0, ih = 1'h0;
   logic        il = 1'h0, conv_valid_i = 1'h0, conv_ready_o, ref_off;
   logic        frame_valid_o, frame_ready_i, unipolar;
   logic [17:0] conv_data_i = 18'h0;
   logic [5:0]  frame_len_o;
   logic [15:0] bits, sum_bits = 16'h0;
   logic [37:0] exp_q[$], got_q[$];
   int          failures = 0, compares = 0;
   always #2.5 clk_i = ~clk_i;
   aofc_frame_ctrl u_dut (.clk_i, .srst_i, .app_rst_i, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
      .device_addr_i(dev), .supply_alarm_high_i(sh), .supply_alarm_low_i(sl),
      .input_alarm_high_i(ih), .input_alarm_low_i(il), .conv_data_i,
      .conv_valid_i, .conv_ready_o, .frame_data_o, .frame_len_o,
      .frame_valid_o, .frame_ready_i, .internal_reference_off_o(ref_off),
      .range_code_o, .range_unipolar_o(unipolar));
   aofc_host_model u_host (.clk_i, .srst_i, .stall_i(stall),
      .frame_valid_i(frame_valid_o), .frame_len_i(frame_len_o),
      .frame_ready_o(frame_ready_i), .bits_o(bits));
   always @(posedge clk_i)
      if (frame_valid_o && frame_ready_i)
         got_q.push_back({frame_len_o, frame_data_o});
   task automatic stop_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic give_up;
      failures++;
      stop_test();
   endtask : give_up
   task automatic chk_reg(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk_reg
   task automatic chk_frame(input logic [37:0] e, g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("BAD frame exp %h got %h", e, g);
      end
   endtask : chk_frame
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge clk_i);
      {psel, pwrite, paddr, pwdata, pstrb} <= {1'h1, w, a, d, s};
      @(posedge clk_i);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready !== 1'h1 && k < 20);
      rd_d = prdata;
      rd_e = pslverr;
      {psel, penable} <= 2'h0;
      if (pready !== 1'h1)
         give_up();
   endtask : apb
   function automatic logic [37:0] mk(input logic [31:0] c, input logic [17:0] d);
      logic [17:0] v;
      logic [31:0] a;
      int          k;
      v = d;
      if (c[2])
         for (int i = 0; i < 18; i++)
            v[i] = c[1] ? (c[0] ? i[1] : i[0]) : c[0];
      a = {14'h0, v};
      k = 18;
      if (c[14]) begin a = {a[27:0], dev}; k += 4; end
      if (c[12]) begin a = {a[30:0], sh}; k++; end
      if (c[13]) begin a = {a[30:0], sl}; k++; end
      if (c[10]) begin a = {a[30:0], ih}; k++; end
      if (c[11]) begin a = {a[30:0], il}; k++; end
      if (c[8]) begin a = {a[27:0], 4'hF}; k += 4; end
      if (c[3]) begin a = {a[29:0], ^v, ^a}; k += 2; end
      return {k[5:0], a << (32 - k)};
   endfunction : mk
   task automatic push(input logic [17:0] d);
      logic [37:0] e;
      int          k;
      e = mk(cur_ctl, d);
      exp_q.push_back(e);
      sum_bits += 16'(e[37:32]);
      @(posedge clk_i);
      conv_data_i <= d;
      conv_valid_i <= 1'h1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (conv_ready_o !== 1'h1 && k < 20);
      conv_valid_i <= 1'h0;
      if (conv_ready_o !== 1'h1)
         give_up();
   endtask : push
   initial begin
      int k;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'h0;
      apb(1'h0, 8'h10, 32'h0, 4'h0);
      chk_reg("ctl_rst", 32'h0, rd_d);
      apb(1'h0, 8'h14, 32'h0, 4'h0);
      chk_reg("rng_rst", 32'h0, rd_d);
      chk_reg("bipolar", 32'h0, {31'h0, unipolar});
      apb(1'h1, 8'h10, 32'hFFFF_FFFF, 4'hF);
      apb(1'h0, 8'h10, 32'h0, 4'h0);
      chk_reg("ctl_all", 32'h0000_7D0F, rd_d);
      apb(1'h1, 8'h10, 32'h0000_0008, 4'h1);
      apb(1'h0, 8'h10, 32'h0, 4'h0);
      chk_reg("ctl_lane", 32'h0000_7D08, rd_d);
      apb(1'h1, 8'h14, 32'hFFFF_FFFF, 4'hF);
      apb(1'h0, 8'h14, 32'h0, 4'h0);
      chk_reg("rng_all", 32'h0000_004F, rd_d);
      chk_reg("ref_off", 32'h1, {31'h0, ref_off});
      chk_reg("unipolar", 32'h1, {31'h0, unipolar});
      @(posedge clk_i);
      app_rst_i <= 1'h1;
      @(posedge clk_i);
      app_rst_i <= 1'h0;
      apb(1'h0, 8'h10, 32'h0, 4'h0);
      chk_reg("ctl_app", 32'h0000_0008, rd_d);
      apb(1'h0, 8'h14, 32'h0, 4'h0);
      chk_reg("rng_app", 32'h0000_000F, rd_d);
      chk_reg("ref_app", 32'h0, {31'h0, ref_off});
      apb(1'h0, 8'h20, 32'h0, 4'h0);
      chk_reg("unmapped", 32'h1, {31'h0, rd_e});
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         {sh, sl, ih, il} <= 4'(i) + 4'h5;
         cur_ctl = {17'h0, i[1], i[1:0], ~i[2:1], 1'h0, i[2], 4'h0, ~i[0],
                    i[2:0]};
         apb(1'h1, 8'h10, cur_ctl, 4'hF);
         push({i[2:0], 15'h4B2D} ^ 18'h2A5C3);
      end
      @(negedge clk_i);
      chk_reg("conv_ready", 32'h0, {31'h0, conv_ready_o});
      @(posedge clk_i);
      stall <= 1'h0;
      k = 0;
      while (got_q.size() < 8 && k < 100) begin
         @(posedge clk_i);
         k++;
      end
      if (got_q.size() < 8)
         give_up();
      foreach (exp_q[j])
         chk_frame(exp_q[j], got_q[j]);
      apb(1'h1, 8'h18, 32'hFFFF_FFFF, 4'hF);
      chk_reg("cnt_err", 32'h0, {31'h0, rd_e});
      apb(1'h0, 8'h18, 32'h0, 4'h0);
      chk_reg("frame_cnt", 32'h8, rd_d);
      repeat (2) @(posedge clk_i);
      chk_reg("host_bits", {16'h0, sum_bits}, {16'h0, bits});
      stop_test();
   end
endmodule : aofc_frame_ctrl_tb
